// >>> rtl/twowire_seq_master.sv
// Master end: runs the whole move into single-conversion mode as one
// scripted transaction of START, bytes, a copy wait and STOP.
// Assumes it is the only master and the sensor never stretches SCL.
module twowire_seq_master #(
    parameter logic [6:0] BUS_ADDR = twowire_seq_pkg::BUS_ADDR_DEF,
    parameter int QCYC = twowire_seq_pkg::QUARTER_CYC,
    parameter int WAIT_CYC = twowire_seq_pkg::COPY_WAIT_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Bus side
    twowire_if.master bus,
    // User request
    input wire logic go_in,
    input wire logic [7:0] cfg_msb_in,
    // User status
    output logic busy_out,
    output logic done_out,
    output logic nack_out
);

    // Counter widths
    localparam int QW = $clog2(QCYC + 1);
    localparam int WW = $clog2(WAIT_CYC + 1);

    // Quarter slots and waits need at least one cycle each
    if (QCYC < 1 || WAIT_CYC < 1) begin : g_chk
        $error("QCYC and WAIT_CYC must be at least one");
    end

    // Bus slot kinds
    typedef enum logic [2:0] {
        MS_IDLE = 3'b000,
        MS_COND = 3'b001,
        MS_BITS = 3'b010,
        MS_ACK = 3'b011,
        MS_WAIT = 3'b100,
        MS_STOP = 3'b101
    } master_state_t;

    master_state_t state_r;
    master_state_t state_nxt;
    logic [3:0] step_r;
    logic [3:0] step_nxt;
    logic [2:0] bit_r;
    logic [2:0] bit_nxt;
    logic [1:0] q_r;
    logic [1:0] q_nxt;
    logic [QW-1:0] div_r;
    logic [WW-1:0] wait_r;
    logic [7:0] byte_r;
    logic [7:0] cfg_r;
    logic scl_r;
    logic sda_r;
    logic nack_r;
    logic done_r;

    // Script: op and byte for each step
    function automatic logic [9:0] script(input logic [3:0] s,
                                          input logic [7:0] cfg);
        logic [7:0] aw;
        aw = {BUS_ADDR, 1'b0}; // R1
        unique case (s)
            4'h0, 4'h3, 4'h7, 4'hB: script = {twowire_seq_pkg::OP_START,
                                              8'h00}; // R4
            4'h1, 4'h4, 4'h8, 4'hC: script = {twowire_seq_pkg::OP_BYTE, aw};
            4'h2: script = {twowire_seq_pkg::OP_BYTE,
                            twowire_seq_pkg::CMD_START_CONV}; // R3
            4'h5: script = {twowire_seq_pkg::OP_BYTE,
                            twowire_seq_pkg::PTR_CFG_MSB}; // R5
            4'h6: script = {twowire_seq_pkg::OP_BYTE,
                            cfg[7:1], 1'b1}; // R6
            4'h9: script = {twowire_seq_pkg::OP_BYTE,
                            twowire_seq_pkg::CMD_COPY_NV}; // R7
            4'hA: script = {twowire_seq_pkg::OP_WAIT, 8'h00}; // R9
            4'hD: script = {twowire_seq_pkg::OP_BYTE,
                            twowire_seq_pkg::CMD_STOP_CONV};
            default: script = {twowire_seq_pkg::OP_STOP, 8'h00}; // R10
        endcase
    endfunction : script

    // Slot timing
    wire active = (state_r != MS_IDLE) && (state_r != MS_WAIT);
    wire tick = active && (div_r == QW'(QCYC - 1));
    wire slot_end = tick && (q_r == 2'h3);
    wire wait_end = (state_r == MS_WAIT) && (wait_r == WW'(WAIT_CYC - 1));
    // Next step of the script and its decode
    wire [3:0] step_inc = step_r + 4'h1;
    wire [9:0] next_op = script(step_inc, cfg_r);
    wire [1:0] nop = next_op[9:8];
    wire master_state_t nop_state =
        (nop == twowire_seq_pkg::OP_START) ? MS_COND :
        (nop == twowire_seq_pkg::OP_BYTE) ? MS_BITS :
        (nop == twowire_seq_pkg::OP_WAIT) ? MS_WAIT : MS_STOP;
    // Acknowledge sampled in the last cycle of the high time of the ninth clock
    wire ack_sample = tick && (state_r == MS_ACK) && (q_r == 2'h2);

    // Slot sequencing
    always_comb begin
        state_nxt = state_r;
        step_nxt = step_r;
        bit_nxt = bit_r;
        q_nxt = tick ? q_r + 2'h1 : q_r;
        unique case (state_r)
            MS_IDLE: begin
                if (go_in) begin
                    state_nxt = MS_COND;
                    step_nxt = 4'h0;
                end
            end
            MS_BITS: begin
                if (slot_end) begin
                    bit_nxt = bit_r - 3'h1;
                    state_nxt = (bit_r == 3'h0) ? MS_ACK : MS_BITS;
                end
            end
            MS_ACK: begin
                // A missing acknowledge aborts straight to STOP
                if (slot_end) begin
                    state_nxt = nack_r ? MS_STOP : nop_state;
                    step_nxt = nack_r ? twowire_seq_pkg::LAST_STEP : step_inc;
                    bit_nxt = 3'h7;
                end
            end
            MS_COND, MS_WAIT: begin
                if (slot_end || wait_end) begin
                    state_nxt = nop_state;
                    step_nxt = step_inc;
                    bit_nxt = 3'h7;
                end
            end
            MS_STOP: begin
                if (slot_end) begin
                    state_nxt = MS_IDLE; // R10
                end
            end
            default: begin
                state_nxt = MS_IDLE;
            end
        endcase
    end

    // Line levels for the quarter being entered, 1 means released
    wire hi_q = (q_nxt == 2'h1) || (q_nxt == 2'h2);
    wire lvl_bit = byte_r[bit_nxt];
    wire scl_nxt = (state_nxt == MS_IDLE) ? 1'b1 :
                   (state_nxt == MS_WAIT) ? 1'b0 :
                   (state_nxt == MS_STOP) ? (q_nxt != 2'h0) : hi_q;
    wire sda_nxt = (state_nxt == MS_COND) ? (q_nxt[1] == 1'b0) :
                   (state_nxt == MS_BITS) ? lvl_bit :
                   (state_nxt == MS_STOP) ? q_nxt[1] : 1'b1;

    // Sequencer registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= MS_IDLE;
            step_r <= 4'h0;
            bit_r <= 3'h7;
            q_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            step_r <= step_nxt;
            bit_r <= bit_nxt;
            q_r <= active ? q_nxt : 2'h0;
        end
    end

    // Quarter divider and copy wait counter
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_r <= '0;
            wait_r <= '0;
        end else begin
            div_r <= (!active || tick) ? '0 : div_r + QW'(1);
            wait_r <= (state_r == MS_WAIT) ? wait_r + WW'(1) : '0; // R9
        end
    end

    // Byte and configuration capture, line levels
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            byte_r <= 8'h00;
            cfg_r <= 8'h00;
            scl_r <= 1'b1;
            sda_r <= 1'b1;
        end else begin
            if (state_r == MS_IDLE && go_in) begin
                cfg_r <= cfg_msb_in;
            end
            if (step_nxt != step_r) begin
                byte_r <= next_op[7:0];
            end
            scl_r <= scl_nxt;
            sda_r <= sda_nxt;
        end
    end

    // Abort flag held until next request; done pulse
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            nack_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            if (state_r == MS_IDLE && go_in) begin
                nack_r <= 1'b0;
            end else if (ack_sample && bus.sda_line) begin
                nack_r <= 1'b1;
            end
            done_r <= (state_r == MS_STOP) && slot_end;
        end
    end

    // Open-drain outputs: drive low when the level is low
    assign bus.m_scl_out = 1'b0;
    assign bus.m_scl_oe_n = scl_r;
    assign bus.m_sda_out = 1'b0;
    assign bus.m_sda_oe_n = sda_r;
    assign busy_out = (state_r != MS_IDLE);
    assign done_out = done_r;
    assign nack_out = nack_r;

endmodule : twowire_seq_master

// >>> rtl/twowire_seq_pkg.sv
// Shared constants for the two-wire mode configuration sequence.
// Assumes one 40 MHz system clock at both ends and a pulled-up bus.
package twowire_seq_pkg;

    // System clock period in ns
    localparam int CLK_PERIOD_NS = 25;
    // Bus clock period in ns (100 kHz standard rate)
    localparam int SCL_PERIOD_NS = 10000;
    // Quarter of a bit slot in clock cycles, rounded up
    localparam int QUARTER_CYC =
        (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
    // Time the nonvolatile copy may take, in ms
    localparam int COPY_WAIT_MS = 10;
    // The same time in clock cycles, rounded up
    localparam int COPY_WAIT_CYC =
        (COPY_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Sensor bus address; the value is arbitrary
    localparam logic [6:0] BUS_ADDR_DEF = 7'h2A;

    // Command and pointer bytes
    localparam logic [7:0] CMD_START_CONV = 8'h51;
    localparam logic [7:0] CMD_STOP_CONV = 8'h22;
    localparam logic [7:0] CMD_COPY_NV = 8'h48;
    localparam logic [7:0] PTR_CFG_MSB = 8'hAC;

    // Configuration byte reset value and mode bit position
    localparam logic [7:0] CFG_MSB_RST = 8'h00;
    localparam int ONESHOT_POS = 0;
    // Data bits in one byte
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Master script operations
    localparam logic [1:0] OP_START = 2'h0;
    localparam logic [1:0] OP_BYTE = 2'h1;
    localparam logic [1:0] OP_WAIT = 2'h2;
    localparam logic [1:0] OP_STOP = 2'h3;
    // Index of the last script step
    localparam logic [3:0] LAST_STEP = 4'hE;

endpackage : twowire_seq_pkg

// >>> rtl/twowire_if.sv
// Open-drain two-wire bus joining the master end and the sensor end.
// Assumes external pull-ups: a line is high unless some end drives it.
interface twowire_if;

    // Master drives the clock and data lines
    logic m_scl_out;
    logic m_scl_oe_n;
    logic m_sda_out;
    logic m_sda_oe_n;
    // Sensor drives data only, no clock stretching
    logic s_sda_out;
    logic s_sda_oe_n;
    // Resolved wire levels
    logic scl_line;
    logic sda_line;

    // Wired-AND with pull-up
    assign scl_line = m_scl_oe_n | m_scl_out;
    assign sda_line = (m_sda_oe_n | m_sda_out) & (s_sda_oe_n | s_sda_out);

    modport master (
        output m_scl_out, m_scl_oe_n, m_sda_out, m_sda_oe_n,
        input scl_line, sda_line
    );
    modport sensor (
        output s_sda_out, s_sda_oe_n,
        input scl_line, sda_line
    );

endinterface : twowire_if

// >>> rtl/temp_sensor_end.sv
// Sensor end of the two-wire bus: a write-only command interpreter
// that handles start and stop of conversion, the configuration MSB
// shadow byte and its copy into nonvolatile storage.
// Assumes bus lines are synchronous to clk_in and the master keeps
// data stable while the clock is high except for START and STOP.
//
// Contract
// R1 - Master opens with START and address, write
// R2 - Sensor acknowledges address and every following byte
// R3 - Command 51h starts conversions after acknowledge
// R4 - Repeated START, not STOP, between commands
// R5 - Pointer ACh steers next byte into shadow
// R6 - Data bit0 one selects single conversion mode
// R7 - Command 48h copies shadow into nonvolatile store
// R8 - Command 22h acknowledged, conversions then stop
// R9 - Master waits for copy before stop command
// R10 - Master ends with STOP after last acknowledge
// R11 - Mode bit zero means continuous conversion
module temp_sensor_end #(
    parameter logic [6:0] BUS_ADDR = twowire_seq_pkg::BUS_ADDR_DEF,
    parameter int COPY_CYC = twowire_seq_pkg::COPY_WAIT_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Bus side
    twowire_if.sensor bus,
    // Sensor state seen by the user side
    output logic converting_out,
    output logic single_conversion_select_out,
    output logic continuous_mode_out,
    output logic nonvolatile_busy_flag_out,
    output logic [7:0] cfg_msb_shadow_out,
    output logic [7:0] cfg_msb_nv_out
);

    // Width of the copy-busy counter
    localparam int CW = $clog2(COPY_CYC + 1);

    // A zero-length copy would leave the copy-busy counter with no width
    if (COPY_CYC < 1) begin : g_chk
        $error("COPY_CYC must be at least one");
    end

    // Protocol states: one per expected byte, plus idle and skip
    typedef enum logic [2:0] {
        SS_IDLE = 3'b000,
        SS_ADDR = 3'b001,
        SS_CMD = 3'b010,
        SS_DATA = 3'b011,
        SS_SKIP = 3'b100
    } sensor_state_t;

    sensor_state_t state_r;
    sensor_state_t state_nxt;

    // Previous line samples for edge and condition detection
    logic scl_q_r;
    logic sda_q_r;
    // Bits received so far in this byte
    logic [3:0] bit_cnt_r;
    // Byte shift register, MSB first
    logic [7:0] shift_r;
    // Acknowledge being driven during the ninth clock
    logic ack_r;
    // Sensor state
    logic converting_r;
    logic [7:0] shadow_r;
    logic [7:0] nv_r;
    logic nv_busy_r;
    logic [CW-1:0] copy_cnt_r;

    // Line events
    wire scl_rise = bus.scl_line & ~scl_q_r;
    wire scl_fall = ~bus.scl_line & scl_q_r;
    wire both_high = bus.scl_line & scl_q_r;
    wire start_det = both_high & sda_q_r & ~bus.sda_line;
    wire stop_det = both_high & ~sda_q_r & bus.sda_line;

    // Byte reception is active only in the byte-taking states
    wire receiving = (state_r == SS_ADDR) || (state_r == SS_CMD) ||
                     (state_r == SS_DATA);
    wire byte_full = (bit_cnt_r == twowire_seq_pkg::BITS_PER_BYTE);
    wire take_bit = scl_rise & receiving & ~byte_full & ~ack_r;
    // Eighth clock has fallen: the byte is complete
    wire byte_done = scl_fall & receiving & byte_full & ~ack_r;
    // Ninth clock has fallen: acknowledge is over
    wire ack_end = scl_fall & ack_r;

    // Address match with write direction only
    wire addr_hit = (shift_r[7:1] == BUS_ADDR) & ~shift_r[0]; // R1
    // Command decode on a completed command byte
    wire in_cmd = byte_done & (state_r == SS_CMD);
    wire cmd_start = in_cmd & (shift_r == twowire_seq_pkg::CMD_START_CONV);
    wire cmd_stop = in_cmd & (shift_r == twowire_seq_pkg::CMD_STOP_CONV);
    wire cmd_copy = in_cmd & (shift_r == twowire_seq_pkg::CMD_COPY_NV);
    wire cmd_ptr = in_cmd & (shift_r == twowire_seq_pkg::PTR_CFG_MSB);
    // Data byte after the pointer lands in the shadow copy
    wire data_wr = byte_done & (state_r == SS_DATA); // R5
    // A copy asked for while one runs is dropped, not restarted
    wire copy_go = cmd_copy & ~nv_busy_r; // R7
    wire copy_last = nv_busy_r & (copy_cnt_r == CW'(1));
    // Acknowledge a matching address and every later byte
    wire ack_go = byte_done & ((state_r != SS_ADDR) | addr_hit); // R2

    // Next protocol state; STOP wins over everything
    always_comb begin
        state_nxt = state_r;
        if (stop_det) begin
            state_nxt = SS_IDLE;
        end else if (start_det) begin
            // Repeated START re-opens address phase
            state_nxt = SS_ADDR;
        end else if (byte_done) begin
            unique case (state_r)
                SS_ADDR: begin
                    state_nxt = addr_hit ? SS_CMD : SS_SKIP;
                end
                SS_CMD: begin
                    state_nxt = cmd_ptr ? SS_DATA : SS_CMD; // R5
                end
                SS_DATA: begin
                    // Further data bytes overwrite the shadow byte
                    state_nxt = SS_DATA;
                end
                SS_IDLE, SS_SKIP: begin
                    state_nxt = state_r;
                end
                default: begin
                    state_nxt = SS_IDLE;
                end
            endcase
        end
    end

    // State register and line samples
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= SS_IDLE;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            scl_q_r <= bus.scl_line;
            sda_q_r <= bus.sda_line;
        end
    end

    // Bit counter and shift register; conditions restart the byte
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
        end else if (start_det || stop_det || ack_end) begin
            bit_cnt_r <= 4'h0;
        end else if (take_bit) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            shift_r <= {shift_r[6:0], bus.sda_line};
        end
    end

    // Acknowledge driver: low from the eighth fall to the ninth fall
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_r <= 1'b0;
        end else if (start_det || stop_det || ack_end) begin
            ack_r <= 1'b0;
        end else if (ack_go) begin
            ack_r <= 1'b1; // R2
        end
    end

    // Conversion run flag; begins with the acknowledge of 51h
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            converting_r <= 1'b0;
        end else if (cmd_start) begin
            converting_r <= 1'b1; // R3
        end else if (cmd_stop) begin
            converting_r <= 1'b0; // R8
        end
    end

    // Shadow and nonvolatile configuration bytes
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shadow_r <= twowire_seq_pkg::CFG_MSB_RST;
            nv_r <= twowire_seq_pkg::CFG_MSB_RST;
        end else begin
            if (data_wr) begin
                shadow_r <= shift_r; // R5
            end
            if (copy_go) begin
                nv_r <= shadow_r; // R7
            end
        end
    end

    // Busy flag held for the copy time; a stop command is not
    // refused while it is set
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            nv_busy_r <= 1'b0;
            copy_cnt_r <= '0;
        end else if (copy_go) begin
            nv_busy_r <= 1'b1; // R7
            copy_cnt_r <= CW'(COPY_CYC);
        end else if (nv_busy_r) begin
            copy_cnt_r <= copy_cnt_r - CW'(1);
            if (copy_last) begin
                nv_busy_r <= 1'b0;
            end
        end
    end

    // Open-drain data: only pulled low, enable low while driving
    assign bus.s_sda_out = 1'b0;
    assign bus.s_sda_oe_n = ~ack_r;

    // User-side view of the sensor
    assign converting_out = converting_r;
    assign single_conversion_select_out =
        shadow_r[twowire_seq_pkg::ONESHOT_POS]; // R6
    assign continuous_mode_out =
        ~shadow_r[twowire_seq_pkg::ONESHOT_POS]; // R11
    assign nonvolatile_busy_flag_out = nv_busy_r;
    assign cfg_msb_shadow_out = shadow_r;
    assign cfg_msb_nv_out = nv_r;

endmodule : temp_sensor_end

// >>> tb/twowire_seq_asserts.sv
// Checker for the mode sequence on the joined bus.
// Assumes it sits beside the interface joining both ends.
module twowire_seq_asserts #(
    parameter int COPY_CYC = 50
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Bus lines and enables
    input wire logic m_scl_oe_n,
    input wire logic m_sda_oe_n,
    input wire logic s_sda_oe_n,
    input wire logic scl_line,
    input wire logic sda_line,
    // Master user side
    input wire logic go_in,
    input wire logic busy_out,
    input wire logic done_out,
    // Sensor user side
    input wire logic converting_out,
    input wire logic single_conversion_select_out,
    input wire logic continuous_mode_out,
    input wire logic nonvolatile_busy_flag_out,
    input wire logic [7:0] cfg_msb_shadow_out,
    input wire logic [7:0] cfg_msb_nv_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // Cycles the busy flag has stood
    logic [31:0] nvb_cnt_r;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) nvb_cnt_r <= '0;
        else nvb_cnt_r <= nonvolatile_busy_flag_out ? nvb_cnt_r + 32'h1 : '0;
    end

    AST_MODE_INV: assert property (continuous_mode_out ==
        !single_conversion_select_out) else $error("mode outputs clash");
    AST_MODE_BIT: assert property (single_conversion_select_out ==
        cfg_msb_shadow_out[0]) else $error("mode bit not from shadow");
    // Ack edges only while the clock line is low
    AST_ACK_EDGE: assert property ($changed(s_sda_oe_n) |->
        !scl_line) else $error("ack moved with clock high");
    AST_ACK_HOLD: assert property ($fell(s_sda_oe_n) |->
        !s_sda_oe_n throughout ##[1:400] $fell(scl_line))
        else $error("ack dropped early");
    AST_NV_COPY: assert property ($rose(nonvolatile_busy_flag_out) |->
        cfg_msb_nv_out == cfg_msb_shadow_out) else $error("copy wrong");
    AST_NV_HOLD: assert property (!$rose(nonvolatile_busy_flag_out) |->
        $stable(cfg_msb_nv_out)) else $error("stored byte changed");
    AST_NVB_LEN: assert property ($fell(nonvolatile_busy_flag_out) |->
        nvb_cnt_r == 32'(COPY_CYC)) else $error("busy length wrong");
    AST_CONV_ON: assert property ($rose(converting_out) |->
        !s_sda_oe_n || $past(!s_sda_oe_n)) else $error("start not acked");
    AST_CONV_OFF: assert property ($fell(converting_out) |->
        !nonvolatile_busy_flag_out && ($past(!s_sda_oe_n) || !s_sda_oe_n))
        else $error("stop early or unacked");
    AST_DONE_IDLE: assert property (done_out |-> scl_line &&
        sda_line && !busy_out ##1 !done_out) else $error("bad finish");
    AST_IDLE_FREE: assert property (!busy_out && !done_out |->
        m_scl_oe_n && m_sda_oe_n) else $error("idle master drives");
    AST_GO_TAKEN: assert property (go_in && !busy_out |=>
        busy_out) else $error("go ignored");
endmodule : twowire_seq_asserts

// >>> tb/oneshot_mode_config_sequence_test.sv
// Bench: master end against sensor end; a hand driver on bus two.
// Assumes package, interface and both ends compiled first.
module oneshot_mode_config_sequence_test;
    timeunit 1ns;
    timeprecision 1ps;
    // Short counts; the wait covers the copy
    localparam int QC = 4;
    localparam int CC = 50;
    localparam int WC = 60;
    localparam logic [6:0] ADDR = twowire_seq_pkg::BUS_ADDR_DEF;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic go_in = 1'b0;
    logic [7:0] cfg_msb_in = 8'h00;
    logic busy_out, done_out, nack_out, conv, sel, cont, nonvolatile_busy_flag;
    logic conv2, sel2, cont2;
    logic [7:0] shadow, nv;
    logic scl_q, sda_q, saw_conv, saw_nvb, oe_q;
    int n_mismatch = 0;
    int checked = 0;
    int n_start, n_stop, n_ack;
    int cycles = 0;
    twowire_if b1();
    twowire_if b2();
    twowire_seq_master #(.QCYC(QC), .WAIT_CYC(WC)) i_twowire_seq_master (
        .clk_in, .rst_n_in, .bus(b1), .go_in, .cfg_msb_in, .busy_out,
        .done_out, .nack_out);
    temp_sensor_end #(.COPY_CYC(CC)) i_temp_sensor_end (
        .clk_in, .rst_n_in, .bus(b1),
        .converting_out(conv), .single_conversion_select_out(sel),
        .continuous_mode_out(cont), .nonvolatile_busy_flag_out(nonvolatile_busy_flag),
        .cfg_msb_shadow_out(shadow), .cfg_msb_nv_out(nv));
    // Second sensor faces the hand driver below
    temp_sensor_end #(.COPY_CYC(CC)) i_temp_sensor_end_2 (
        .clk_in, .rst_n_in, .bus(b2),
        .converting_out(conv2), .single_conversion_select_out(sel2),
        .continuous_mode_out(cont2), .nonvolatile_busy_flag_out(),
        .cfg_msb_shadow_out(), .cfg_msb_nv_out());
    twowire_seq_asserts #(.COPY_CYC(CC)) i_twowire_seq_asserts (
        .clk_in, .rst_n_in,
        .m_scl_oe_n(b1.m_scl_oe_n), .m_sda_oe_n(b1.m_sda_oe_n),
        .s_sda_oe_n(b1.s_sda_oe_n), .scl_line(b1.scl_line),
        .sda_line(b1.sda_line), .go_in, .busy_out,
        .done_out, .converting_out(conv),
        .single_conversion_select_out(sel), .continuous_mode_out(cont),
        .nonvolatile_busy_flag_out(nonvolatile_busy_flag), .cfg_msb_shadow_out(shadow),
        .cfg_msb_nv_out(nv));

    // Clock: 25 ns period
    always #12.5 clk_in = ~clk_in;

    // Counts START, STOP and acks on the main bus
    always @(posedge clk_in) begin
        if (scl_q && b1.scl_line && sda_q && !b1.sda_line) n_start++;
        if (scl_q && b1.scl_line && !sda_q && b1.sda_line) n_stop++;
        // An ack is the fall of the sensor enable, whatever bit0 was
        if (b1.s_sda_oe_n === 1'b0 && oe_q && !b1.scl_line) n_ack++;
        if (conv === 1'b1) saw_conv = 1'b1;
        if (nonvolatile_busy_flag === 1'b1) saw_nvb = 1'b1;
        scl_q = b1.scl_line;
        sda_q = b1.sda_line;
        oe_q = b1.s_sda_oe_n;
    end

    // Hang guard, about twice the expected run
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 10000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : cyc

    // One quarter slot of the hand driver; high means released
    task automatic q2(input logic c, input logic d);
        b2.m_scl_oe_n = c;
        b2.m_sda_oe_n = d;
        cyc(QC);
    endtask : q2

    task automatic start2;
        q2(0, 1); q2(1, 1); q2(1, 0); q2(0, 0);
    endtask : start2

    // Byte MSB first; ack is the line level in the ack slot
    task automatic byte2(input logic [7:0] v, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            q2(0, v[i]); q2(1, v[i]); q2(1, v[i]); q2(0, v[i]);
        end
        q2(0, 1); q2(1, 1); q2(1, 1);
        ack = b2.sda_line;
        q2(0, 1);
    endtask : byte2

    task automatic test_reset;
        check("conv", conv, 0);
        check("shadow", shadow, 8'h00);
        check("nv", nv, 8'h00);
        check("cont", cont, 1);
        check("busy", busy_out, 0);
        $display("test_reset ended");
    endtask : test_reset

    // Full scripted run; bit0 must arrive as 1
    task automatic run_seq(input logic [7:0] cfg);
        int n;
        n_start = 0; n_stop = 0; n_ack = 0;
        saw_conv = 1'b0; saw_nvb = 1'b0;
        go_in = 1'b1; cfg_msb_in = cfg;
        cyc(1);
        go_in = 1'b0;
        n = 0;
        while (done_out !== 1'b1 && n < 4000) begin
            cyc(1);
            n++;
        end
        check("done", done_out, 1);
        check("nack", nack_out, 0);
        check("starts", 8'(n_start), 8'h04);
        check("stops", 8'(n_stop), 8'h01);
        check("acks", 8'(n_ack), 8'h09);
        check("saw conv", saw_conv, 1);
        check("conv", conv, 0);
        check("shadow", shadow, cfg | 8'h01);
        check("nv", nv, cfg | 8'h01);
        check("sel", sel, 1);
        check("cont", cont, 0);
        check("saw nvb", saw_nvb, 1);
        check("nvb", nonvolatile_busy_flag, 0);
        $display("run_seq ended");
    endtask : run_seq

    // Mid-run reset frees the bus at once
    task automatic mid_reset;
        go_in = 1'b1; cfg_msb_in = 8'h3C;
        cyc(1);
        go_in = 1'b0;
        cyc(400);
        check("conv early", conv, 1);
        rst_n_in = 1'b0;
        cyc(2);
        check("scl free", b1.scl_line, 1);
        check("sda free", b1.sda_line, 1);
        check("conv", conv, 0);
        check("sel", sel, 0);
        rst_n_in = 1'b1;
        cyc(2);
        $display("mid_reset ended");
    endtask : mid_reset

    // Hand driver: read direction refused, then writes accepted
    task automatic bad_master;
        logic a;
        start2; byte2({ADDR, 1'b1}, a);
        check("read ack", a, 1);
        start2; byte2({ADDR, 1'b0}, a);
        check("addr ack", a, 0);
        byte2(twowire_seq_pkg::CMD_START_CONV, a);
        check("conv2", conv2, 1);
        start2; byte2({ADDR, 1'b0}, a);
        byte2(twowire_seq_pkg::PTR_CFG_MSB, a);
        byte2(8'h00, a);
        check("data ack", a, 0);
        check("cont2", cont2, 1);
        byte2(8'h01, a);
        check("sel2", sel2, 1);
        q2(0, 0); q2(1, 0); q2(1, 1); q2(1, 1);
        $display("bad_master ended");
    endtask : bad_master

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        b2.m_scl_out = 1'b0; b2.m_sda_out = 1'b0;
        b2.m_scl_oe_n = 1'b1; b2.m_sda_oe_n = 1'b1;
        scl_q = 1'b1; sda_q = 1'b1; oe_q = 1'b1;
        cyc(20);
        rst_n_in = 1'b1;
        cyc(1);
        test_reset();
        run_seq(8'hA4);
        mid_reset();
        run_seq(8'hFF);
        bad_master();
        tally_and_finish();
    end
endmodule : oneshot_mode_config_sequence_test
